// File: common/pmc_consts.svh
// Constants for the privilege mode control block.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_SR_S_BIT 13
`define PMC_SR_RESET 16'h2700
`define PMC_TM_USER_DATA 3'h1
`define PMC_TM_USER_CODE 3'h2
`define PMC_TM_SUP_DATA 3'h5
`define PMC_TM_SUP_CODE 3'h6
`endif

// File: common/pmc_pkg.sv
// Types for the privilege mode control block.
package pmc_pkg;
	typedef enum logic [3:0] {
		PMC_OP_NONE = 4'h0,
		PMC_OP_MOVE_SR = 4'h1,
		PMC_OP_AND_IMM = 4'h2,
		PMC_OP_XOR_IMM = 4'h3,
		PMC_OP_OR_IMM = 4'h4,
		PMC_OP_RET_EXC = 4'h5,
		PMC_OP_HALT = 4'h6,
		PMC_OP_EXT_RESET = 4'h7,
		PMC_OP_CTRL_REG = 4'h8,
		PMC_OP_TRAP = 4'h9,
		PMC_OP_PLAIN = 4'hA
	} pmc_op_t;
	typedef enum logic [2:0] {
		PMC_ST_RUN = 3'b001,
		PMC_ST_PUSH = 3'b010,
		PMC_ST_SETS = 3'b100
	} pmc_state_t;
	typedef struct packed {
		logic valid;
		pmc_op_t op;
		logic [15:0] operand;
	} pmc_instr_t;
	typedef struct packed {
		logic req;
		logic is_code;
		logic is_stack;
	} pmc_access_t;
endpackage

// File: tb/pmc_mem_model.sv
// Memory system model that marks protected pages and decodes cycles.
`timescale 1ns/1ps
`default_nettype none
module pmc_mem_model (
	input wire pmc_pkg::pmc_access_t access,
	input wire logic [2:0] tm_out,
	input wire logic prot,
	output logic page_sup_only,
	output logic seen_sup
);
	// The page is flagged only while a protected cycle is requested.
	assign page_sup_only = access.req & prot;
	// The marking pins tell supervisor cycles from user cycles.
	assign seen_sup = tm_out[2];
endmodule
`default_nettype wire

// File: tb/tb_pmc_top.sv
// Testbench for the privilege mode control block.
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_top;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	pmc_pkg::pmc_instr_t instr = '0;
	logic exc_req = 1'b0;
	pmc_pkg::pmc_access_t access = '0;
	logic prot = 1'b0;
	logic page_sup_only, sup_mode, use_sup_sp, push_sr, flush, seen_sup;
	logic priv_violation, ctrl_reg_grant, halt_go, ext_reset_go;
	logic access_fault, table_sel_sup;
	logic [15:0] sr_out, push_data, last_push;
	logic [2:0] tm_out;
	int fail_count = 0;
	int tests_run = 0;
	int n_pv = 0;
	int n_fl = 0;
	int n_go = 0;
	int n_af = 0;
	pmc_pkg::pmc_op_t pops[8] = '{pmc_pkg::PMC_OP_MOVE_SR,
		pmc_pkg::PMC_OP_AND_IMM, pmc_pkg::PMC_OP_XOR_IMM,
		pmc_pkg::PMC_OP_OR_IMM, pmc_pkg::PMC_OP_RET_EXC,
		pmc_pkg::PMC_OP_HALT, pmc_pkg::PMC_OP_EXT_RESET,
		pmc_pkg::PMC_OP_CTRL_REG};
	pmc_pkg::pmc_op_t uops[3] = '{pmc_pkg::PMC_OP_MOVE_SR,
		pmc_pkg::PMC_OP_AND_IMM, pmc_pkg::PMC_OP_XOR_IMM};
	logic [15:0] uarg[3] = '{16'h0700, 16'hDFFF, 16'h2100};
	logic [15:0] usr[3] = '{16'h0700, 16'h0700, 16'h0600};
	pmc_top pmc_top_inst (.clk_sys(clk_sys), .nrst(nrst), .instr(instr),
		.exc_req(exc_req), .access(access), .page_sup_only(page_sup_only),
		.sr_out(sr_out), .sup_mode(sup_mode), .tm_out(tm_out),
		.use_sup_sp(use_sup_sp), .push_sr(push_sr), .push_data(push_data),
		.flush(flush), .priv_violation(priv_violation),
		.ctrl_reg_grant(ctrl_reg_grant), .halt_go(halt_go),
		.ext_reset_go(ext_reset_go), .access_fault(access_fault),
		.table_sel_sup(table_sel_sup));
	pmc_mem_model pmc_mem_model_inst (.access(access), .tm_out(tm_out),
		.prot(prot), .page_sup_only(page_sup_only), .seen_sup(seen_sup));
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	// ==========================================
	// Pulse counters sampled on the rising edge.
	always @(posedge clk_sys) begin
		if (priv_violation === 1'b1) n_pv++;
		if (flush === 1'b1) n_fl++;
		if ((ctrl_reg_grant | halt_go | ext_reset_go) === 1'b1) n_go++;
		if (access_fault === 1'b1) n_af++;
		if (push_sr === 1'b1) last_push <= push_data;
	end
	// ==========================================
	// Shared tasks.
	task test_done();
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task op(input pmc_pkg::pmc_op_t o, input logic [15:0] d);
		instr = '{1'b1, o, d};
		cyc(1);
		instr = '0;
		cyc(4);
	endtask
	task acc(input logic code, input logic p, input logic [2:0] e);
		access = '{1'b1, code, 1'b0};
		prot = p;
		cyc(1);
		access = '0;
		prot = 1'b0;
		chk(tm_out, e);
		chk(seen_sup, e[2]);
	endtask
	// ==========================================
	// Scenarios.
	task t_sup();
		chk(sr_out, 16'h2700);
		chk(use_sup_sp, 1'b1);
		chk(table_sel_sup, 1'b1);
		acc(1'b1, 1'b0, 3'h6);
		acc(1'b0, 1'b1, 3'h5);
		for (int i = 5; i < 8; i++) op(pops[i], 16'h2700);
		chk(16'(n_go), 16'h0003);
		chk(16'(n_af + n_pv), 16'h0000);
	endtask
	task t_user();
		int f;
		for (int i = 0; i < 3; i++) begin
			f = n_fl;
			op(uops[i], uarg[i]);
			chk(16'(n_fl), 16'(f + 1));
			chk(sup_mode, 1'b0);
			chk(sr_out, usr[i]);
			chk(use_sup_sp, 1'b0);
			chk(table_sel_sup, 1'b0);
			acc(1'b1, 1'b1, 3'h2);
			acc(1'b0, 1'b0, 3'h1);
			chk(16'(n_af), 16'(i + 1));
			op(pmc_pkg::PMC_OP_TRAP, 16'h0000);
			chk(sup_mode, 1'b1);
			chk(last_push, usr[i]);
		end
		chk(16'(n_pv), 16'h0000);
	endtask
	task t_priv();
		for (int i = 0; i < 8; i++) begin
			op(pmc_pkg::PMC_OP_MOVE_SR, 16'h0000);
			op(pops[i], 16'h0000);
			chk(16'(n_pv), 16'(i + 1));
			chk(last_push, 16'h0000);
			chk(use_sup_sp, 1'b1);
			chk(sup_mode, 1'b1);
		end
		chk(16'(n_go), 16'h0003);
	endtask
	task t_exc();
		op(pmc_pkg::PMC_OP_MOVE_SR, 16'h0300);
		exc_req = 1'b1;
		cyc(1);
		exc_req = 1'b0;
		cyc(4);
		chk(sup_mode, 1'b1);
		chk(last_push, 16'h0300);
		acc(1'b0, 1'b0, 3'h5);
	endtask
	initial begin
		#1ms;
		fail_count++;
		test_done();
	end
	initial begin
		cyc(10);
		nrst = 1'b1;
		cyc(1);
		t_sup();
		t_user();
		t_priv();
		t_exc();
		test_done();
	end
endmodule
`default_nettype wire

// File: verilog/pmc_tm_encode.sv
// Transfer-modifier encoder for one bus cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_tm_encode (
	input wire logic sup,
	input wire logic is_code,
	output logic [2:0] tm
);
	// =============================================
	// Encode
	// Supervisor and user cycles get distinct codes.
	always_comb begin
		if (sup) begin
			tm = is_code ? `PMC_TM_SUP_CODE : `PMC_TM_SUP_DATA;
		end else begin
			tm = is_code ? `PMC_TM_USER_CODE : `PMC_TM_USER_DATA;
		end
	end
endmodule
`default_nettype wire

// File: verilog/pmc_top.sv
// Privilege mode control: status word, privilege checks, cycle marking.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_top (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire pmc_pkg::pmc_instr_t instr,
	input wire logic exc_req,
	input wire pmc_pkg::pmc_access_t access,
	input wire logic page_sup_only,
	output logic [15:0] sr_out,
	output logic sup_mode,
	output logic [2:0] tm_out,
	output logic use_sup_sp,
	output logic push_sr,
	output logic [15:0] push_data,
	output logic flush,
	output logic priv_violation,
	output logic ctrl_reg_grant,
	output logic halt_go,
	output logic ext_reset_go,
	output logic access_fault,
	output logic table_sel_sup
);
	// =============================================
	// State
	pmc_pkg::pmc_state_t state_reg;
	logic [15:0] sr_reg;
	logic [15:0] sr_next;
	logic sr_write;
	logic sup;
	logic is_priv;
	logic in_exc;
	logic take_exc;
	logic [2:0] tm_next;
	assign sup = sr_reg[`PMC_SR_S_BIT];
	assign in_exc = (state_reg != pmc_pkg::PMC_ST_RUN);
	// =============================================
	// Privilege decode
	always_comb begin
		unique case (instr.op)
			pmc_pkg::PMC_OP_MOVE_SR,
			pmc_pkg::PMC_OP_AND_IMM,
			pmc_pkg::PMC_OP_XOR_IMM,
			pmc_pkg::PMC_OP_OR_IMM,
			pmc_pkg::PMC_OP_RET_EXC: is_priv = 1'b1;
			pmc_pkg::PMC_OP_HALT,
			pmc_pkg::PMC_OP_EXT_RESET: is_priv = 1'b1;
			pmc_pkg::PMC_OP_CTRL_REG: is_priv = 1'b1;
			default: is_priv = 1'b0;
		endcase
	end
	// A violation aborts the instruction and raises an exception.
	assign take_exc = exc_req || (instr.valid && !sup && is_priv)
		|| (instr.valid && instr.op == pmc_pkg::PMC_OP_TRAP);
	// =============================================
	// Status word update
	always_comb begin
		sr_next = sr_reg;
		sr_write = 1'b0;
		if (!in_exc && instr.valid && sup && !exc_req) begin
			sr_write = 1'b1;
			unique case (instr.op)
				pmc_pkg::PMC_OP_MOVE_SR,
				pmc_pkg::PMC_OP_RET_EXC: sr_next = instr.operand;
				pmc_pkg::PMC_OP_AND_IMM: sr_next = sr_reg & instr.operand;
				pmc_pkg::PMC_OP_XOR_IMM: sr_next = sr_reg ^ instr.operand;
				pmc_pkg::PMC_OP_OR_IMM: sr_next = sr_reg | instr.operand;
				default: sr_write = 1'b0;
			endcase
		end
	end
	// =============================================
	// Exception sequencer
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_reg <= pmc_pkg::PMC_ST_RUN;
		end else begin
			unique case (state_reg)
				pmc_pkg::PMC_ST_RUN: begin
					if (take_exc && !(instr.valid && sup && sr_write)) begin
						state_reg <= pmc_pkg::PMC_ST_PUSH;
					end
				end
				pmc_pkg::PMC_ST_PUSH: state_reg <= pmc_pkg::PMC_ST_SETS;
				pmc_pkg::PMC_ST_SETS: state_reg <= pmc_pkg::PMC_ST_RUN;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sr_reg <= `PMC_SR_RESET;
		end else if (state_reg == pmc_pkg::PMC_ST_PUSH) begin
			sr_reg[`PMC_SR_S_BIT] <= 1'b1;
		end else if (sr_write) begin
			sr_reg <= sr_next;
		end
	end
	// =============================================
	// Stack push of the old status word
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			push_sr <= 1'b0;
			push_data <= 16'h0000;
		end else begin
			push_sr <= (state_reg == pmc_pkg::PMC_ST_RUN) && take_exc
				&& !sr_write;
			push_data <= sr_reg;
		end
	end
	// =============================================
	// Pipeline flush
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flush <= 1'b0;
		end else begin
			flush <= sr_write;
		end
	end
	// =============================================
	// Cycle marking
	pmc_tm_encode u_tm (
		.sup(sup || in_exc),
		.is_code(access.is_code),
		.tm(tm_next)
	);
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tm_out <= `PMC_TM_SUP_DATA;
			use_sup_sp <= 1'b1;
			sup_mode <= 1'b1;
			sr_out <= `PMC_SR_RESET;
		end else begin
			tm_out <= tm_next;
			use_sup_sp <= sup || in_exc || (state_reg == pmc_pkg::PMC_ST_RUN
				&& take_exc);
			sup_mode <= sup;
			sr_out <= sr_reg;
		end
	end
	// =============================================
	// Privileged actions and translation check
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			priv_violation <= 1'b0;
			ctrl_reg_grant <= 1'b0;
			halt_go <= 1'b0;
			ext_reset_go <= 1'b0;
			access_fault <= 1'b0;
			table_sel_sup <= 1'b1;
		end else begin
			priv_violation <= instr.valid && !sup && is_priv;
			ctrl_reg_grant <= instr.valid && sup
				&& instr.op == pmc_pkg::PMC_OP_CTRL_REG;
			halt_go <= instr.valid && sup
				&& instr.op == pmc_pkg::PMC_OP_HALT;
			ext_reset_go <= instr.valid && sup
				&& instr.op == pmc_pkg::PMC_OP_EXT_RESET;
			access_fault <= access.req && page_sup_only
				&& !(sup || in_exc);
			table_sel_sup <= sup || in_exc;
		end
	end
	// =============================================
	// Checks
	sequence s_entry;
		state_reg == pmc_pkg::PMC_ST_PUSH;
	endsequence
	sequence s_set;
		push_sr && (push_data == sr_reg)
			##1 (state_reg == pmc_pkg::PMC_ST_SETS) && sup;
	endsequence
	chk_push_then_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_entry |-> s_set)
		else $error("Flag not set after status push.");
	chk_user_halt_blocked: assert property (@(posedge clk_sys) disable iff (!nrst)
		instr.valid && !sup && instr.op == pmc_pkg::PMC_OP_HALT |=> !halt_go)
		else $error("Halt taken in user state.");
	chk_ctrl_reg_user: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctrl_reg_grant |-> $past(sup))
		else $error("Control register granted in user state.");
	chk_flush_after_sr: assert property (@(posedge clk_sys) disable iff (!nrst)
		sr_write |=> flush)
		else $error("No flush after status word change.");
	chk_user_priv_trap: assert property (@(posedge clk_sys) disable iff (!nrst)
		instr.valid && !sup && is_priv && !in_exc |=> s_entry ##0 sr_reg == $past(sr_reg))
		else $error("Privileged op in user did not trap.");
	chk_exc_cycle_sup: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_exc |=> tm_out[2])
		else $error("Exception cycle marked as user.");
	chk_user_cycle_user: assert property (@(posedge clk_sys) disable iff (!nrst)
		!sup && !in_exc |=> !tm_out[2])
		else $error("User cycle marked as supervisor.");
	chk_user_fault: assert property (@(posedge clk_sys) disable iff (!nrst)
		access.req && page_sup_only && !sup && !in_exc |=> access_fault)
		else $error("User access to protected page not blocked.");
	chk_stack_sup: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_exc |=> use_sup_sp)
		else $error("Exception stack not supervisor.");
endmodule
`default_nettype wire
